// >>> rtl/txdd_desc_mem.sv
// Descriptor holding buffer with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module txdd_desc_mem (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write port
  input  wire logic        we,
  input  wire logic [1:0]  waddr,
  input  wire logic [31:0] wdata,
  // Read port
  input  wire logic [1:0]  raddr,
  output var  logic [31:0] rdata
);

  txdd_pkg::txdd_mem_t m_q;
  txdd_pkg::txdd_mem_t m_d;

  // Read data always lag the address by one cycle.
  always_comb begin
    m_d = m_q;
    m_d.rdata = m_q.words[raddr];
    if (we) begin
      m_d.words[waddr] = wdata;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign rdata = m_q.rdata;

endmodule // txdd_desc_mem
`default_nettype wire

// >>> rtl/txdd_map.svh
// Register offsets, field positions, reset values and sizes of the block.
// ****************************************************************
// ****************************************************************
`ifndef TXDD_MAP_SVH
`define TXDD_MAP_SVH

// Register offsets on the software port.
`define TXDD_REG_CMD     8'h00
`define TXDD_REG_PTR     8'h04
`define TXDD_REG_CFG     8'h08
`define TXDD_REG_STAT    8'h0C
`define TXDD_REG_REMAIN  8'h10
`define TXDD_REG_FRAG    8'h14

// Field positions.
`define TXDD_CMD_RUN      0
`define TXDD_STAT_IDLE    0
`define TXDD_STAT_DONE    1
`define TXDD_STAT_RUN     2
`define TXDD_STAT_PEND    3
`define TXDD_CS_OWN       31
`define TXDD_CS_MORE      30
`define TXDD_CFG_WORDS_LO 16

// Reset values.
`define TXDD_THR_RST     12'h040
`define TXDD_WORDS_RST   4'h3

// Descriptor layout and completion write placement.
`define TXDD_DESC_DEPTH  4
`define TXDD_W_LINK      2'h0
`define TXDD_W_CS        2'h1
`define TXDD_W_PTR       2'h2
`define TXDD_CS_HI_OFS   32'h0000_0006
`define TXDD_CS_HI_LEN   12'h002
`define TXDD_WORD_LEN    12'h004

`endif

// >>> rtl/txdd_pkg.sv
// Types shared by the transmit descriptor engine files.
`default_nettype none
package txdd_pkg;

  // Machine states, one-hot.
  typedef enum logic [7:0] {
    STATE_IDLE          = 8'h01,
    STATE_DESC_READ     = 8'h02,
    STATE_LINK_REFRESH  = 8'h04,
    STATE_UNPACK        = 8'h08,
    STATE_FIFO_WAIT     = 8'h10,
    STATE_FRAGMENT_READ = 8'h20,
    STATE_STATUS_WRITE  = 8'h40,
    STATE_ADVANCE       = 8'h80
  } txdd_state_t;

  // Whole state of the engine.
  typedef struct packed {
    txdd_state_t st;
    logic        tx_run_request;
    logic        tx_desc_done_flag;
    logic        tx_idle_status;
    logic [31:0] tx_desc_pointer;
    logic [11:0] fill_level_threshold;
    logic [3:0]  desc_words;
    logic [31:0] link;
    logic [31:0] cmdsts;
    logic [31:0] fragment_pointer;
    logic [11:0] remaining_desc_bytes;
    logic [1:0]  fetch;
    logic [3:0]  wcnt;
    logic        wr_final;
    logic        ret_wait;
    logic        pend;
    logic [15:0] pend_status;
    logic [31:0] pend_handle;
    logic        bm_req;
    logic        bm_write;
    logic [31:0] bm_addr;
    logic [11:0] bm_len;
    logic [31:0] bm_wdata;
    logic [3:0]  bm_first_be;
    logic [3:0]  bm_last_be;
    logic        hdl_valid;
    logic [31:0] hdl_data;
    logic [31:0] reg_rdata;
  } txdd_regs_t;

  // Descriptor holding buffer state.
  typedef struct packed {
    logic [3:0][31:0] words;
    logic [31:0]      rdata;
  } txdd_mem_t;

endpackage : txdd_pkg
`default_nettype wire

// >>> rtl/txdd_top.sv
// Transmit descriptor engine: list walker filling the transmit data FIFO.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "txdd_map.svh"
module txdd_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Bus master request
  output logic             bm_req,
  output logic             bm_write,
  output logic      [31:0] bm_addr,
  output logic      [11:0] bm_len,
  output logic      [31:0] bm_wdata,
  output logic      [3:0]  bm_first_be,
  output logic      [3:0]  bm_last_be,
  // Bus master answer
  input  wire logic        transfer_complete,
  input  wire logic        bm_rdata_valid,
  input  wire logic [31:0] bm_rdata,
  // Transmit data FIFO
  input  wire logic [11:0] fifo_free_bytes,
  output logic             hdl_valid,
  output logic      [31:0] hdl_data,
  // Packet completion from the transmitter
  input  wire logic        pkt_done,
  input  wire logic [15:0] pkt_status,
  input  wire logic [31:0] pkt_handle
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Byte lanes lo..hi of one word; serves both ends of a burst.
  function automatic logic [3:0] be_mask(input logic [1:0] lo,
                                         input logic [1:0] hi);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      m[i] = (2'(i) >= lo) && (2'(i) <= hi);
    end
    return m;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************

  txdd_pkg::txdd_regs_t s_q;
  txdd_pkg::txdd_regs_t s_d;

  logic        mem_we;
  logic [1:0]  mem_waddr;
  logic [1:0]  mem_raddr;
  logic [31:0] mem_rdata;
  logic        fifo_space_event;
  logic        go;
  logic        go_wr;
  logic [31:0] go_addr;
  logic [11:0] go_len;
  logic [31:0] go_wdata;
  logic [11:0] frag_len;
  logic [1:0]  end_lane;
  logic        run_set;

  txdd_desc_mem u_desc_holding_buffer (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (bm_rdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // Space test on the raw free count; same clock, so no synchroniser.
  assign fifo_space_event =
    fifo_free_bytes > s_q.fill_level_threshold;

  // Burst size is whichever is smaller, free space or what is left.
  assign frag_len = (fifo_free_bytes < s_q.remaining_desc_bytes) ?
                    fifo_free_bytes : s_q.remaining_desc_bytes;

  // Descriptor words land in the buffer as they arrive.
  assign mem_we    = bm_rdata_valid &&
                     (s_q.st == txdd_pkg::STATE_DESC_READ) &&
                     (s_q.wcnt < 4'(`TXDD_DESC_DEPTH));
  assign mem_waddr = s_q.wcnt[1:0];
  assign mem_raddr = s_q.fetch;

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Register port, request bookkeeping and the list walker.
  always_comb begin
    s_d       = s_q;
    s_d.bm_req    = 1'b0;
    s_d.hdl_valid = 1'b0;
    s_d.reg_rdata = 32'h0000_0000;
    go        = 1'b0;
    go_wr     = 1'b0;
    go_addr   = s_q.tx_desc_pointer;
    go_len    = `TXDD_WORD_LEN;
    go_wdata  = 32'h0000_0000;
    run_set   = 1'b0;
    end_lane  = 2'h0;

    // Software writes.
    if (reg_wr) begin
      unique case (reg_addr)
        `TXDD_REG_CMD: begin
          if (reg_wdata[`TXDD_CMD_RUN]) begin
            s_d.tx_run_request = 1'b1;
            run_set = 1'b1;
          end
        end
        `TXDD_REG_PTR: begin
          s_d.tx_desc_pointer   = reg_wdata;
          s_d.tx_desc_done_flag = 1'b0;
        end
        `TXDD_REG_CFG: begin
          s_d.fill_level_threshold = reg_wdata[11:0];
          s_d.desc_words = reg_wdata[`TXDD_CFG_WORDS_LO +: 4];
        end
        `TXDD_REG_STAT: begin
          if (reg_wdata[`TXDD_STAT_IDLE]) begin
            s_d.tx_idle_status = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Software reads; unmapped offsets answer zero.
    if (reg_rd) begin
      unique case (reg_addr)
        `TXDD_REG_CMD:
          s_d.reg_rdata[`TXDD_CMD_RUN] = s_q.tx_run_request;
        `TXDD_REG_PTR:
          s_d.reg_rdata = s_q.tx_desc_pointer;
        `TXDD_REG_CFG:
          s_d.reg_rdata = {12'h000, s_q.desc_words, 4'h0,
                           s_q.fill_level_threshold};
        `TXDD_REG_STAT: begin
          s_d.reg_rdata[`TXDD_STAT_IDLE] = s_q.tx_idle_status;
          s_d.reg_rdata[`TXDD_STAT_DONE] = s_q.tx_desc_done_flag;
          s_d.reg_rdata[`TXDD_STAT_RUN]  = s_q.tx_run_request;
          s_d.reg_rdata[`TXDD_STAT_PEND] = s_q.pend;
          s_d.reg_rdata[15:8]            = s_q.st;
        end
        `TXDD_REG_REMAIN:
          s_d.reg_rdata = {20'h00000, s_q.remaining_desc_bytes};
        `TXDD_REG_FRAG:
          s_d.reg_rdata = s_q.fragment_pointer;
        default: begin
        end
      endcase
    end

    // One completion is held; a second before service replaces it.
    if (pkt_done) begin
      s_d.pend        = 1'b1;
      s_d.pend_status = pkt_status;
      s_d.pend_handle = pkt_handle;
    end

    // Count arriving descriptor words; a refresh keeps the link only.
    if (bm_rdata_valid) begin
      if (s_q.st == txdd_pkg::STATE_LINK_REFRESH) begin
        if (s_q.wcnt == 4'h0) begin
          s_d.link = bm_rdata;
        end
        s_d.wcnt = s_q.wcnt + 4'h1;
      end else if (s_q.st == txdd_pkg::STATE_DESC_READ) begin
        s_d.wcnt = s_q.wcnt + 4'h1;
      end
    end

    unique case (s_q.st)
      txdd_pkg::STATE_IDLE: begin
        if (s_q.pend) begin
          s_d.ret_wait = 1'b0;
          s_d.wr_final = 1'b1;
          s_d.st = txdd_pkg::STATE_STATUS_WRITE;
        end else if (s_q.tx_run_request) begin
          s_d.wcnt = 4'h0;
          go = 1'b1;
          if (!s_q.tx_desc_done_flag) begin
            go_len = {6'h00, s_q.desc_words, 2'h0};
            s_d.st = txdd_pkg::STATE_DESC_READ;
          end else begin
            go_len = `TXDD_WORD_LEN;
            s_d.st = txdd_pkg::STATE_LINK_REFRESH;
          end
        end
      end
      txdd_pkg::STATE_DESC_READ: begin
        if (transfer_complete) begin
          s_d.fetch = `TXDD_W_LINK;
          s_d.st = txdd_pkg::STATE_UNPACK;
        end
      end
      txdd_pkg::STATE_LINK_REFRESH: begin
        if (transfer_complete) begin
          s_d.st = txdd_pkg::STATE_ADVANCE;
        end
      end
      txdd_pkg::STATE_UNPACK: begin
        // Buffer reads lag one cycle, so each word lands a step later.
        s_d.fetch = s_q.fetch + 2'h1;
        if (s_q.fetch == `TXDD_W_CS) begin
          s_d.link = mem_rdata;
        end else if (s_q.fetch == `TXDD_W_PTR) begin
          s_d.cmdsts = mem_rdata;
        end else if (s_q.fetch == 2'h3) begin
          s_d.fetch = `TXDD_W_LINK;
          s_d.fragment_pointer = mem_rdata;
          s_d.remaining_desc_bytes = s_q.cmdsts[11:0];
          if (s_q.cmdsts[`TXDD_CS_OWN]) begin
            s_d.st = txdd_pkg::STATE_FIFO_WAIT;
          end else begin
            s_d.tx_idle_status = 1'b1;
            s_d.st = txdd_pkg::STATE_IDLE;
          end
        end
      end
      txdd_pkg::STATE_FIFO_WAIT: begin
        if (s_q.pend) begin
          s_d.ret_wait = 1'b1;
          s_d.wr_final = 1'b1;
          s_d.st = txdd_pkg::STATE_STATUS_WRITE;
        end else if (s_q.remaining_desc_bytes == 12'h000) begin
          if (s_q.cmdsts[`TXDD_CS_MORE]) begin
            s_d.wr_final = 1'b0;
            s_d.st = txdd_pkg::STATE_STATUS_WRITE;
          end else begin
            s_d.hdl_valid = 1'b1;
            s_d.hdl_data  = s_q.tx_desc_pointer;
            s_d.st = txdd_pkg::STATE_ADVANCE;
          end
        end else if (fifo_space_event) begin
          go = 1'b1;
          go_addr = s_q.fragment_pointer;
          go_len  = frag_len;
          s_d.fragment_pointer = s_q.fragment_pointer + {20'h00000, frag_len};
          s_d.remaining_desc_bytes = s_q.remaining_desc_bytes - frag_len;
          s_d.st = txdd_pkg::STATE_FRAGMENT_READ;
        end
      end
      txdd_pkg::STATE_FRAGMENT_READ: begin
        if (transfer_complete) begin
          s_d.st = txdd_pkg::STATE_FIFO_WAIT;
        end
      end
      txdd_pkg::STATE_STATUS_WRITE: begin
        // The write is issued on entry, seen by the state changing into this one.
        if (transfer_complete) begin
          if (!s_q.wr_final) begin
            s_d.st = txdd_pkg::STATE_ADVANCE;
          end else if (s_q.ret_wait) begin
            s_d.st = txdd_pkg::STATE_FIFO_WAIT;
          end else begin
            s_d.st = txdd_pkg::STATE_IDLE;
          end
        end
      end
      txdd_pkg::STATE_ADVANCE: begin
        if (s_q.link != 32'h0000_0000) begin
          s_d.tx_desc_pointer   = s_q.link;
          s_d.tx_desc_done_flag = 1'b0;
          s_d.wcnt = 4'h0;
          go = 1'b1;
          go_addr = s_q.link;
          go_len  = {6'h00, s_q.desc_words, 2'h0};
          s_d.st = txdd_pkg::STATE_DESC_READ;
        end else begin
          s_d.tx_desc_done_flag = 1'b1;
          s_d.tx_idle_status    = 1'b1;
          s_d.tx_run_request    = run_set;
          s_d.st = txdd_pkg::STATE_IDLE;
        end
      end
    endcase

    // Status writes touch only the upper half of the command word.
    if ((s_d.st == txdd_pkg::STATE_STATUS_WRITE) &&
        (s_q.st != txdd_pkg::STATE_STATUS_WRITE)) begin
      go    = 1'b1;
      go_wr = 1'b1;
      go_len = `TXDD_CS_HI_LEN;
      if (s_d.wr_final) begin
        go_addr  = s_q.pend_handle + `TXDD_CS_HI_OFS;
        go_wdata = {1'b0, s_q.pend_status[14:0], 16'h0000};
        s_d.pend = pkt_done;
      end else begin
        go_addr  = s_q.tx_desc_pointer + `TXDD_CS_HI_OFS;
        go_wdata = {1'b0, s_q.cmdsts[30:16], 16'h0000};
      end
    end

    // Launch one request with byte lanes for unaligned ends.
    if (go) begin
      end_lane = 2'(go_addr[1:0] + go_len[1:0] - 2'h1);
      s_d.bm_req      = 1'b1;
      s_d.bm_write    = go_wr;
      s_d.bm_addr     = go_addr;
      s_d.bm_len      = go_len;
      s_d.bm_wdata    = go_wdata;
      s_d.bm_first_be = be_mask(go_addr[1:0], 2'h3);
      s_d.bm_last_be  = be_mask(2'h0, end_lane);
    end
  end

  // ****************************************************************
  // Registers and outputs
  // ****************************************************************

  // Single state register for the whole engine.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= txdd_pkg::STATE_IDLE;
      s_q.fill_level_threshold <= `TXDD_THR_RST;
      s_q.desc_words <= `TXDD_WORDS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a field of the state register.
  assign reg_rdata   = s_q.reg_rdata;
  assign bm_req      = s_q.bm_req;
  assign bm_write    = s_q.bm_write;
  assign bm_addr     = s_q.bm_addr;
  assign bm_len      = s_q.bm_len;
  assign bm_wdata    = s_q.bm_wdata;
  assign bm_first_be = s_q.bm_first_be;
  assign bm_last_be  = s_q.bm_last_be;
  assign hdl_valid   = s_q.hdl_valid;
  assign hdl_data    = s_q.hdl_data;

endmodule // txdd_top
`default_nettype wire

// >>> tb/txdd_host_mem.sv
// Host memory answering the engine's bus-master bursts.
`timescale 1ns/1ps
`default_nettype none
module txdd_host_mem (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request from the engine
  input  wire logic        bm_req,
  input  wire logic        bm_write,
  input  wire logic [31:0] bm_addr,
  input  wire logic [11:0] bm_len,
  input  wire logic [31:0] bm_wdata,
  // Answer to the engine
  input  wire logic        slow,
  output logic             transfer_complete,
  output logic             bm_rdata_valid,
  output logic      [31:0] bm_rdata
);
  // ********
  // Memory
  // ********
  logic [31:0] mem [256];
  logic        busy;
  logic [7:0]  a;
  logic [9:0]  n;
  logic [1:0]  w;

  // One burst at a time; slow mode inserts wait cycles before each word.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {busy, a, n, w, transfer_complete, bm_rdata_valid} <= '0;
      bm_rdata <= 32'h0;
    end else begin
      transfer_complete <= 1'b0;
      bm_rdata_valid    <= 1'b0;
      // The data line never holds its last value between words.
      bm_rdata <= ~bm_rdata;
      if (bm_req) begin
        busy <= 1'b1;
        a    <= bm_addr[9:2];
        n    <= bm_write ? 10'h0 : 10'((bm_len + 12'h3) >> 2);
        w    <= {2{slow}};
        if (bm_write)
          mem[bm_addr[9:2]][31:16] <= bm_wdata[31:16];
      end else if (busy) begin
        if (w != 2'h0)
          w <= w - 2'h1;
        else if (n != 10'h0) begin
          bm_rdata_valid <= 1'b1;
          bm_rdata       <= mem[a];
          a              <= a + 8'h1;
          n              <= n - 10'h1;
          w              <= {2{slow}};
        end else begin
          transfer_complete <= 1'b1;
          busy              <= 1'b0;
        end
      end
    end
  end
endmodule // txdd_host_mem
`default_nettype wire

// >>> tb/txdd_top_sva.sv
// Concurrent checks on the transmit descriptor engine ports.
`timescale 1ns/1ps
`default_nettype none
`include "txdd_map.svh"
module txdd_top_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Bus master and FIFO side
  input wire logic        bm_req,
  input wire logic        bm_write,
  input wire logic [31:0] bm_addr,
  input wire logic [11:0] bm_len,
  input wire logic [31:0] bm_wdata,
  input wire logic [11:0] fifo_free_bytes,
  input wire logic        hdl_valid
);
  // ********
  // Checks
  // ********
  logic [31:0] ptr_w_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Pointer last written by software, the address a restart must read.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ptr_w_q <= 32'h0;
    else if (reg_wr && reg_addr == `TXDD_REG_PTR)
      ptr_w_q <= reg_wdata;
  end

  // Requests and handles are single-cycle pulses.
  req_pulse_a: assert property (bm_req |=> !bm_req)
    else $error("bus request held past one cycle");
  hdl_pulse_a: assert property (hdl_valid |=> !hdl_valid)
    else $error("handle push held past one cycle");
  // Status writes touch only the upper half, owner cleared.
  wr_len_a: assert property (
    bm_req && bm_write |-> bm_len == 12'h002)
    else $error("status write not two bytes");
  wr_low_a: assert property (
    bm_req && bm_write |-> bm_wdata[15:0] == 16'h0)
    else $error("status write carries lower half data");
  wr_owner_a: assert property (bm_req && bm_write |-> !bm_wdata[31])
    else $error("status write keeps owner bit");
  // No empty bursts; a long burst never exceeds free space.
  zero_burst_a: assert property (bm_req |-> bm_len != 12'h000)
    else $error("zero length burst");
  frag_len_a: assert property (
    bm_req && !bm_write && bm_len > 12'h03C
    |-> bm_len <= $past(fifo_free_bytes))
    else $error("fragment burst larger than free space");
  // A fresh pointer followed by a run request reads that pointer.
  ptr_read_a: assert property (
    (reg_wr && reg_addr == `TXDD_REG_PTR) ##2
    (reg_wr && reg_addr == `TXDD_REG_CMD && reg_wdata[0]) |-> ##[1:3]
    (bm_req && !bm_write && bm_addr == ptr_w_q))
    else $error("restart did not read the written pointer");

  // Main scenarios.
  status_c: cover property (bm_req && bm_write);
  handle_c: cover property (hdl_valid);
  long_c: cover property (bm_req && bm_len > 12'h03C);
endmodule // txdd_top_sva

bind txdd_top txdd_top_sva i_sva (.clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .bm_req, .bm_write, .bm_addr, .bm_len, .bm_wdata,
  .fifo_free_bytes, .hdl_valid);
`default_nettype wire

// >>> tb/txdd_top_tb.sv
// Self-checking bench for the transmit descriptor engine.
`timescale 1ns/1ps
`default_nettype none
`include "txdd_map.svh"
module txdd_top_tb;
  // ********
  // Bench
  // ********
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [11:0] fifo_free_bytes = 12'h048;
  logic        pkt_done = 1'b0;
  logic [15:0] pkt_status = 16'h0;
  logic [31:0] pkt_handle = 32'h0;
  logic        slow = 1'b0;
  logic [31:0] reg_rdata, bm_addr, bm_wdata, bm_rdata, hdl_data;
  logic        bm_req, bm_write, transfer_complete, bm_rdata_valid;
  logic        hdl_valid;
  logic [11:0] bm_len;
  logic [3:0]  bm_first_be, bm_last_be;
  logic [52:0] bq[$];
  logic [31:0] hq[$];
  int          fail_count = 0;
  int          n_checks = 0;

  // Clock at 10 MHz.
  always #50 clk = ~clk;

  txdd_top i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .bm_req, .bm_write, .bm_addr, .bm_len, .bm_wdata,
    .bm_first_be, .bm_last_be, .transfer_complete, .bm_rdata_valid,
    .bm_rdata, .fifo_free_bytes, .hdl_valid, .hdl_data, .pkt_done,
    .pkt_status, .pkt_handle);
  txdd_host_mem i_mem (.clk, .rst_n, .bm_req, .bm_write, .bm_addr,
    .bm_len, .bm_wdata, .slow, .transfer_complete, .bm_rdata_valid,
    .bm_rdata);

  // Log each request and handle in the one cycle it stands.
  always @(posedge clk) begin
    if (bm_req === 1'b1)
      bq.push_back({bm_write, bm_addr, bm_len, bm_first_be, bm_last_be});
    if (hdl_valid === 1'b1)
      hq.push_back(hdl_data);
  end

  // Compare and count; case inequality so unknowns never match.
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Register write; an idle cycle follows so strobes never merge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Register read; data is taken in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask

  // Place a descriptor: link, command word, fragment pointer.
  task automatic desc(input logic [31:0] p, l, c, f);
    i_mem.mem[p[9:2]]     = l;
    i_mem.mem[p[9:2] + 1] = c;
    i_mem.mem[p[9:2] + 2] = f;
  endtask

  // Wait for n logged requests, then for the machine to rest in idle.
  task automatic to_idle(input int n);
    logic [31:0] s;
    for (int i = 0; i < 800 && bq.size() < n; i++) @(posedge clk);
    s = 32'h0;
    for (int i = 0; i < 100 && s[15:8] !== 8'h01; i++)
      rd(`TXDD_REG_STAT, s);
  endtask

  // Reset values, pointer read-back and an unmapped offset.
  task automatic t_regs;
    logic [31:0] d;
    rd(`TXDD_REG_CFG, d);
    chk(d, 32'h0003_0040);
    rd(`TXDD_REG_STAT, d);
    chk(d, 32'h0000_0100);
    rd(8'h20, d);
    chk(d, 32'h0);
    wr(`TXDD_REG_PTR, 32'h1234_5679);
    rd(`TXDD_REG_PTR, d);
    chk(d, 32'h1234_5679);
  endtask

  // One packet, odd fragment address, space held at the threshold first.
  // A completion served while blocked must come back to the FIFO wait.
  task automatic t_single;
    logic [31:0] d;
    desc(32'h100, 32'h0, 32'h8000_0070, 32'h203);
    fifo_free_bytes <= 12'h020;
    wr(`TXDD_REG_CFG, 32'h0003_0020);
    wr(`TXDD_REG_PTR, 32'h100);
    wr(`TXDD_REG_CMD, 32'h1);
    repeat (30) @(posedge clk);
    rd(`TXDD_REG_STAT, d);
    chk(d[15:8], 8'h10);
    chk(bq.size(), 1);
    rd(`TXDD_REG_REMAIN, d);
    chk(d, 32'h0000_0070);
    rd(`TXDD_REG_FRAG, d);
    chk(d, 32'h0000_0203);
    pkt_handle <= 32'h1C0;
    pkt_status <= 16'h1234;
    pkt_done   <= 1'b1;
    @(posedge clk);
    pkt_done <= 1'b0;
    repeat (20) @(posedge clk);
    rd(`TXDD_REG_STAT, d);
    chk(d[15:8], 8'h10);
    chk(i_mem.mem[8'h71][31:16], 16'h1234);
    fifo_free_bytes <= 12'h048;
    to_idle(4);
    chk(bq.pop_front(), {1'b0, 32'h100, 12'h00C, 8'hFF});
    chk(bq.pop_front(), {1'b1, 32'h1C6, 12'h002, 8'hCF});
    chk(bq.pop_front(), {1'b0, 32'h203, 12'h048, 8'h87});
    chk(bq.pop_front(), {1'b0, 32'h24B, 12'h028, 8'h87});
    chk(hq.pop_front(), 32'h100);
    rd(`TXDD_REG_STAT, d);
    chk(d, 32'h0000_0103);
    chk(bq.size(), 0);
  endtask

  // Refresh of a done list, then a two-descriptor packet, slow memory.
  task automatic t_chain;
    logic [31:0] d;
    slow <= 1'b1;
    i_mem.mem[8'h40] = 32'h140;
    desc(32'h140, 32'h180, 32'hC000_0004, 32'h301);
    desc(32'h180, 32'h0, 32'h8000_0005, 32'h305);
    wr(`TXDD_REG_CMD, 32'h1);
    to_idle(6);
    chk(bq.pop_front(), {1'b0, 32'h100, 12'h004, 8'hFF});
    chk(bq.pop_front(), {1'b0, 32'h140, 12'h00C, 8'hFF});
    chk(bq.pop_front(), {1'b0, 32'h301, 12'h004, 8'hE1});
    chk(bq.pop_front(), {1'b1, 32'h146, 12'h002, 8'hCF});
    chk(bq.pop_front(), {1'b0, 32'h180, 12'h00C, 8'hFF});
    chk(bq.pop_front(), {1'b0, 32'h305, 12'h005, 8'hE3});
    chk(hq.pop_front(), 32'h180);
    chk(i_mem.mem[8'h51], 32'h4000_0004);
    chk(i_mem.mem[8'h61], 32'h8000_0005);
    rd(`TXDD_REG_STAT, d);
    chk(d[2:0], 3'h3);
  endtask

  // Packet completion writes status into the last descriptor.
  task automatic t_status;
    pkt_handle <= 32'h180;
    pkt_status <= 16'hABCD;
    pkt_done   <= 1'b1;
    @(posedge clk);
    pkt_done <= 1'b0;
    to_idle(1);
    chk(bq.pop_front(), {1'b1, 32'h186, 12'h002, 8'hCF});
    chk(i_mem.mem[8'h61], 32'h2BCD_0005);
  endtask

  // A descriptor not handed over sends the machine back to idle.
  task automatic t_unowned;
    logic [31:0] d;
    slow <= 1'b0;
    desc(32'h1C0, 32'h0, 32'h0000_0010, 32'h400);
    wr(`TXDD_REG_STAT, 32'h1);
    wr(`TXDD_REG_PTR, 32'h1C0);
    wr(`TXDD_REG_CMD, 32'h1);
    to_idle(2);
    chk(bq.pop_front(), {1'b0, 32'h1C0, 12'h00C, 8'hFF});
    chk(bq.pop_front(), {1'b0, 32'h1C0, 12'h00C, 8'hFF});
    rd(`TXDD_REG_STAT, d);
    chk(d[1:0], 2'h1);
  endtask

  // Print the counts and the verdict, then stop.
  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence after 16 cycles of reset.
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_single();
    t_chain();
    t_status();
    t_unowned();
    results();
  end

  // The run needs a few hundred cycles; give up far beyond that.
  initial begin
    #(100 * 20000);
    fail_count++;
    results();
  end
endmodule // txdd_top_tb
`default_nettype wire
